/* File: rtl/clk_shutdown_regs.v */
/*
 * register file and clock-management state of the sensor: accepts spi-side
 * word writes, gates the logic clock and the pll, tracks acquisition and
 * flags static registers rewritten while frames are being acquired.
 * assumes an spi front end that delivers one aligned write strobe per word
 * in the mclk domain; reference clock selection pins come from outside.
 */
// Notes on behaviour
// RULE1 - host: logic off, clock gate, clkgen reset
// RULE2 - host: logic-off value depends on mode
// RULE3 - host: pll off, pll reset, clock mgmt
// RULE4 - device stops internal clocking after uploads
// RULE5 - host resets sensor before stopping clock
// RULE6 - reference clock is pll pin or lvds
// RULE7 - frame rate, exposure accepted in any state
// RULE8 - gain changes accepted in any state
// RULE9 - windowing, subsampling accepted in any state
// RULE10 - host: static writes only when sequencer off
// RULE11 - host: no static rewrites during acquisition
// RULE12 - static rewrite during acquisition corrupts frames
// RULE13 - host: reserved registers keep defaults
// RULE14 - host: 0x0003 starts, 0x0002 stops sequencer
// RULE15 - host: uploads in order, one at a time
`include "clk_shutdown_consts.vh"
`default_nettype none

module clk_shutdown_regs (
  input wire mclk,
  input wire srst,
  input wire wrStrobe,
  input wire [8:0] wrAddr,
  input wire [15:0] wrData,
  input wire [8:0] rdAddr,
  input wire pllBypass,
  input wire pllClkPin,
  input wire lvdsClkPin,
  output reg [15:0] rdData,
  output reg logicClkOn,
  output reg logicBlocksOn,
  output reg clkGenInReset,
  output reg pllOn,
  output reg pllInReset,
  output reg refClk,
  output reg acquiring,
  output reg frameCorrupt,
  output reg acqHalted
);

  localparam ST_STANDBY = 2'b00;
  localparam ST_IDLE = 2'b01;
  localparam ST_RUNNING = 2'b10;

  reg [15:0] clockGen_q;
  reg [15:0] logicEnable_q;
  reg [15:0] pllEnable_q;
  reg [15:0] clockMgmt_q;
  reg [15:0] pllSoftReset_q;
  reg [15:0] clkgenSoftReset_q;
  reg [15:0] imageCore_q;
  reg [15:0] frontEnd_q;
  reg [15:0] serialTx_q;
  reg [15:0] seqCtrl_q;
  reg [15:0] bias_q [0:7];
  reg [1:0] state_q;
  reg [1:0] state_d;
  wire pllSync;
  wire lvdsSync;
  wire bypassSync;
  integer i;

  // true for the static group that must not move during acquisition
  function isStatic;
    input [8:0] a;
    begin
      isStatic = (a == `ADDR_CLOCK_GEN) || (a == `ADDR_IMAGE_CORE) ||
                 (a == `ADDR_FRONT_END) || (a == `ADDR_SERIAL_TX) ||
                 ((a >= `ADDR_BIAS_FIRST) && (a <= `ADDR_BIAS_LAST));
    end
  endfunction

  wire wrStatic = wrStrobe & isStatic(wrAddr);

  ////////////////////////////////////////////////////////////////////////////
  // register writes; frame-rate, exposure, gain and window registers live
  // elsewhere and are never gated by state here
  always @(posedge mclk) begin
    if (srst) begin
      clockGen_q <= `RST_CLOCK_GEN;
      logicEnable_q <= `RST_LOGIC_ENABLE;
      pllEnable_q <= `RST_PLL_ENABLE;
      clockMgmt_q <= `RST_CLOCK_MGMT;
      pllSoftReset_q <= `RST_OTHER;
      clkgenSoftReset_q <= `RST_OTHER;
      imageCore_q <= `RST_OTHER;
      frontEnd_q <= `RST_OTHER;
      serialTx_q <= `RST_OTHER;
      seqCtrl_q <= `RST_OTHER;
      for (i = 0; i < 8; i = i + 1) begin
        bias_q[i] <= `RST_OTHER;
      end
    end else if (wrStrobe) begin // RULE7 RULE8 RULE9
      case (wrAddr)
        `ADDR_CLOCK_GEN: clockGen_q <= wrData;
        `ADDR_LOGIC_ENABLE: logicEnable_q <= wrData;
        `ADDR_PLL_ENABLE: pllEnable_q <= wrData;
        `ADDR_CLOCK_MGMT: clockMgmt_q <= wrData;
        `ADDR_PLL_SOFT_RESET: pllSoftReset_q <= wrData;
        `ADDR_CLKGEN_SOFT_RESET: clkgenSoftReset_q <= wrData;
        `ADDR_IMAGE_CORE: imageCore_q <= wrData;
        `ADDR_FRONT_END: frontEnd_q <= wrData;
        `ADDR_SERIAL_TX: serialTx_q <= wrData;
        `ADDR_SEQ_CTRL: seqCtrl_q <= wrData;
        default: begin
          if ((wrAddr >= `ADDR_BIAS_FIRST) && (wrAddr <= `ADDR_BIAS_LAST)) begin
            bias_q[wrAddr[2:0]] <= wrData;
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sensor state: standby while logic is off, idle, running on sequencer bit
  always @* begin
    state_d = ST_IDLE;
    if (logicEnable_q == `VAL_ZERO) begin
      state_d = ST_STANDBY;
    end else if (seqCtrl_q[`BIT_SEQ_ENABLE]) begin
      state_d = ST_RUNNING;
    end
  end

  always @(posedge mclk) begin
    if (srst) begin
      state_q <= ST_STANDBY;
    end else begin
      case (state_d)
        ST_STANDBY: state_q <= ST_STANDBY;
        ST_IDLE: state_q <= ST_IDLE;
        ST_RUNNING: state_q <= ST_RUNNING;
        default: state_q <= ST_STANDBY;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // clocking outputs follow the shutdown uploads
  always @(posedge mclk) begin
    if (srst) begin
      logicClkOn <= 1'b1;
      logicBlocksOn <= 1'b1;
      clkGenInReset <= 1'b0;
      pllOn <= 1'b1;
      pllInReset <= 1'b0;
      acquiring <= 1'b0;
    end else begin
      logicBlocksOn <= logicEnable_q != `VAL_ZERO; // RULE4
      logicClkOn <= clockGen_q[`BIT_LOGIC_CLK_ON]; // RULE4
      clkGenInReset <= clkgenSoftReset_q == `VAL_CLKGEN_RESET; // RULE4
      pllOn <= (pllEnable_q != `VAL_ZERO) && (clockMgmt_q != `VAL_ZERO); // RULE4
      pllInReset <= pllSoftReset_q == `VAL_PLL_RESET; // RULE4
      acquiring <= state_q == ST_RUNNING;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // reference clock pins come from outside, so each is synchronised
  sync3 uPllSync (.mclk(mclk), .srst(srst), .din(pllClkPin), .dout(pllSync));
  sync3 uLvdsSync (.mclk(mclk), .srst(srst), .din(lvdsClkPin), .dout(lvdsSync));
  sync3 uBypSync (.mclk(mclk), .srst(srst), .din(pllBypass), .dout(bypassSync));

  always @(posedge mclk) begin
    if (srst) begin
      refClk <= 1'b0;
    end else begin
      refClk <= bypassSync ? lvdsSync : pllSync; // RULE6
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // a static rewrite while running flags a corrupt frame; a clock-generator
  // rewrite sets acqHalted, which holds until the sensor leaves the running state
  always @(posedge mclk) begin
    if (srst) begin
      frameCorrupt <= 1'b0;
      acqHalted <= 1'b0;
    end else begin
      frameCorrupt <= wrStatic && (state_q == ST_RUNNING); // RULE12
      if (wrStatic && (state_q == ST_RUNNING) && (wrAddr == `ADDR_CLOCK_GEN)) begin
        acqHalted <= 1'b1; // RULE12
      end else if (state_q != ST_RUNNING) begin
        acqHalted <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read port; unmapped addresses read zero
  always @(posedge mclk) begin
    if (srst) begin
      rdData <= 16'h0000;
    end else begin
      case (rdAddr)
        `ADDR_CLOCK_GEN: rdData <= clockGen_q;
        `ADDR_LOGIC_ENABLE: rdData <= logicEnable_q;
        `ADDR_PLL_ENABLE: rdData <= pllEnable_q;
        `ADDR_CLOCK_MGMT: rdData <= clockMgmt_q;
        `ADDR_PLL_SOFT_RESET: rdData <= pllSoftReset_q;
        `ADDR_CLKGEN_SOFT_RESET: rdData <= clkgenSoftReset_q;
        `ADDR_IMAGE_CORE: rdData <= imageCore_q;
        `ADDR_FRONT_END: rdData <= frontEnd_q;
        `ADDR_SERIAL_TX: rdData <= serialTx_q;
        `ADDR_SEQ_CTRL: rdData <= seqCtrl_q;
        default: begin
          if ((rdAddr >= `ADDR_BIAS_FIRST) && (rdAddr <= `ADDR_BIAS_LAST)) begin
            rdData <= bias_q[rdAddr[2:0]];
          end else begin
            rdData <= 16'h0000;
          end
        end
      endcase
    end
  end

endmodule // clk_shutdown_regs

`default_nettype wire

/* File: common/clk_shutdown_consts.vh */
/*
 * constants for the clock-management shutdown block: register addresses,
 * mode-dependent values and field positions.
 * assumes inclusion by bare name from the design files.
 */
`ifndef CLK_SHUTDOWN_CONSTS_VH
`define CLK_SHUTDOWN_CONSTS_VH

// register addresses (spi word addresses, 9 bits)
`define ADDR_PLL_SOFT_RESET 9'h008
`define ADDR_CLKGEN_SOFT_RESET 9'h009
`define ADDR_PLL_ENABLE 9'h010
`define ADDR_CLOCK_MGMT 9'h014
`define ADDR_CLOCK_GEN 9'h020
`define ADDR_LOGIC_ENABLE 9'h022
`define ADDR_IMAGE_CORE 9'h028
`define ADDR_FRONT_END 9'h030
`define ADDR_BIAS_FIRST 9'h040
`define ADDR_BIAS_LAST 9'h047
`define ADDR_SERIAL_TX 9'h070
`define ADDR_SEQ_CTRL 9'h0C0

// shutdown and sequencer values
`define VAL_ZERO 16'h0000
`define VAL_CLKGEN_RESET 16'h0009
`define VAL_PLL_RESET 16'h0099
`define VAL_LOGIC_OFF_8_PLL 16'h200C
`define VAL_LOGIC_OFF_8_NOPLL 16'h2008
`define VAL_LOGIC_OFF_10_PLL 16'h2004
`define VAL_LOGIC_OFF_10_NOPLL 16'h2000
`define VAL_SEQ_START 16'h0003
`define VAL_SEQ_STOP 16'h0002

// field positions
`define BIT_SEQ_ENABLE 0
`define BIT_LOGIC_CLK_ON 1
`define BIT_PLL_SELECT 2

// reset values of the register file
`define RST_CLOCK_GEN 16'h200F
`define RST_LOGIC_ENABLE 16'h0001
`define RST_PLL_ENABLE 16'h0001
`define RST_CLOCK_MGMT 16'h0001
`define RST_OTHER 16'h0000

`endif

/* File: rtl/sync3.v */
/*
 * three-stage synchroniser for a pin input; the output changes only when
 * the second and third stages agree.
 * assumes mclk domain, synchronous active-high reset.
 */
`default_nettype none

module sync3 (
  input wire mclk,
  input wire srst,
  input wire din,
  output reg dout
);

  reg s1_q;
  reg s2_q;
  reg s3_q;

  // first stage feeds only the second stage
  always @(posedge mclk) begin
    if (srst) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
      dout <= 1'b0;
    end else begin
      s1_q <= din;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q) begin
        dout <= s3_q;
      end
    end
  end

endmodule // sync3

`default_nettype wire

/* File: verification/clk_shutdown_chk_asserts.sv */
/* port-level checker for clk_shutdown_regs.
   assumes one mclk domain and the shared register-map header. */
`include "clk_shutdown_consts.vh"
`default_nettype none
module clk_shutdown_chk (
  input wire mclk,
  input wire srst,
  input wire wrStrobe,
  input wire [8:0] wrAddr,
  input wire [15:0] wrData,
  input wire [8:0] rdAddr,
  input wire pllBypass,
  input wire pllClkPin,
  input wire lvdsClkPin,
  input wire [15:0] rdData,
  input wire logicClkOn,
  input wire logicBlocksOn,
  input wire clkGenInReset,
  input wire pllOn,
  input wire pllInReset,
  input wire refClk,
  input wire acquiring,
  input wire frameCorrupt,
  input wire acqHalted
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge mclk); endclocking
  default disable iff (srst);
  // address and data fused; idle strobe maps to an unused pattern
  wire [24:0] wr = wrStrobe ? {wrAddr, wrData} : 25'h1FFFFFF;
  a_logic_off: assert property (wr == {`ADDR_LOGIC_ENABLE, `VAL_ZERO} |->
    ##[2:3] !logicBlocksOn) else $error("logic blocks stayed on");
  a_clk_gate: assert property (wrStrobe && wrAddr == `ADDR_CLOCK_GEN &&
    !wrData[`BIT_LOGIC_CLK_ON] |->
    ##[2:3] !logicClkOn) else $error("logic clock not gated");
  a_clkgen_reset: assert property (wr == {`ADDR_CLKGEN_SOFT_RESET, `VAL_CLKGEN_RESET} |->
    ##[2:3] clkGenInReset) else $error("clock generator not reset");
  a_pll_off: assert property (wr == {`ADDR_PLL_ENABLE, `VAL_ZERO} |->
    ##[2:3] !pllOn) else $error("pll stayed on");
  a_pll_reset: assert property (wr == {`ADDR_PLL_SOFT_RESET, `VAL_PLL_RESET} |->
    ##[2:3] pllInReset) else $error("pll not reset");
  a_ref_lvds: assert property ((pllBypass && lvdsClkPin) [*6] |-> refClk)
    else $error("lvds clock not selected");
  a_ref_pll: assert property ((!pllBypass && !pllClkPin) [*6] |-> !refClk)
    else $error("pll pin not selected");
  a_static_corrupt: assert property (acquiring && wrStrobe && wrAddr == `ADDR_FRONT_END |->
    ##[1:3] frameCorrupt) else $error("static rewrite not flagged");
  a_gen_halt: assert property (acquiring && wrStrobe && wrAddr == `ADDR_CLOCK_GEN |->
    ##[1:3] acqHalted) else $error("halt not flagged");
  a_unmapped_read: assert property ($stable(rdAddr) && rdAddr == 9'h1FF |=> rdData == 16'h0000)
    else $error("unmapped read not zero");
  c_corrupt: cover property (acquiring ##1 frameCorrupt);
  c_halt: cover property (acqHalted);
  c_all_off: cover property (clkGenInReset && pllInReset && !pllOn);
endmodule // clk_shutdown_chk
bind clk_shutdown_regs clk_shutdown_chk clk_shutdown_chk_inst (.mclk, .srst, .wrStrobe,
  .wrAddr, .wrData, .rdAddr, .pllBypass, .pllClkPin, .lvdsClkPin, .rdData, .logicClkOn,
  .logicBlocksOn, .clkGenInReset, .pllOn, .pllInReset, .refClk, .acquiring, .frameCorrupt,
  .acqHalted);
`default_nettype wire

/* File: verification/host_shutdown_model.sv */
/* host model: issues the six clock-shutdown uploads on go.
   assumes mode bit1 = 10-bit, bit0 = no pll. */
`include "clk_shutdown_consts.vh"
`default_nettype none
module host_shutdown_model (
  input wire logic mclk,
  input wire logic srst,
  input wire logic go,
  input wire logic [1:0] mode,
  output var logic hStb,
  output var logic [8:0] hAddr,
  output var logic [15:0] hData,
  output var logic done
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] idx;
  // one strobe then an idle cycle: each write ends before the next
  always @(posedge mclk) begin
    if (srst) begin
      idx <= 4'h0;
      hStb <= 1'b0;
    end else if (go) begin
      idx <= 4'h1;
    end else if (idx != 4'h0) begin
      hStb <= !hStb;
      if (hStb) idx <= (idx == 4'h6) ? 4'h0 : idx + 4'h1;
    end
  end
  assign done = (idx == 4'h0);
  // upload table; off value steps down by 4 per mode
  always_comb begin
    case (idx)
      4'h1: {hAddr, hData} = {`ADDR_LOGIC_ENABLE, `VAL_ZERO};
      4'h2: {hAddr, hData} = {`ADDR_CLOCK_GEN, 16'h200C - {12'h000, mode, 2'h0}};
      4'h3: {hAddr, hData} = {`ADDR_CLKGEN_SOFT_RESET, `VAL_CLKGEN_RESET};
      4'h4: {hAddr, hData} = {`ADDR_PLL_ENABLE, `VAL_ZERO};
      4'h5: {hAddr, hData} = {`ADDR_PLL_SOFT_RESET, `VAL_PLL_RESET};
      default: {hAddr, hData} = {`ADDR_CLOCK_MGMT, `VAL_ZERO};
    endcase
  end
endmodule // host_shutdown_model
`default_nettype wire

/* File: verification/sensor_clock_shutdown_and_reconfig_tb_top.sv */
/* self-checking bench for clk_shutdown_regs with a host shutdown model.
   assumes 25 MHz mclk and status outputs settling two edges after a write. */
`include "clk_shutdown_consts.vh"
`default_nettype none
module sensor_clock_shutdown_and_reconfig_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk = 1'b0, srst = 1'b1, tStb = 1'b0, go = 1'b0, hStb, done, fc;
  logic pllBypass = 1'b0, pllClkPin = 1'b0, lvdsClkPin = 1'b0;
  logic [8:0] tAddr = 9'h000, rdAddr = 9'h000, hAddr;
  logic [15:0] tData = 16'h0000, hData, rdData;
  logic [1:0] mode = 2'h0;
  wire [7:0] st;
  int failures = 0, n_compared = 0, cyc = 0;
  logic [40:0] rows [0:5] = '{{9'h028, 16'h0003, 16'h0003}, {9'h030, 16'h0001, 16'h0001},
    {9'h040, 16'h0001, 16'h0001}, {9'h047, 16'h00AB, 16'h00AB},
    {9'h070, 16'h0007, 16'h0007}, {9'h1FF, 16'hFFFF, 16'h0000}};
  logic [15:0] offTab [0:3] = '{16'h200C, 16'h2008, 16'h2004, 16'h2000};
  clk_shutdown_regs clk_shutdown_regs_inst (.mclk(mclk), .srst(srst),
    .wrStrobe(tStb | hStb), .wrAddr(hStb ? hAddr : tAddr), .wrData(hStb ? hData : tData),
    .rdAddr(rdAddr), .pllBypass(pllBypass), .pllClkPin(pllClkPin), .lvdsClkPin(lvdsClkPin),
    .rdData(rdData), .logicClkOn(st[7]), .logicBlocksOn(st[6]), .clkGenInReset(st[5]),
    .pllOn(st[4]), .pllInReset(st[3]), .refClk(), .acquiring(st[2]),
    .frameCorrupt(st[1]), .acqHalted(st[0]));
  host_shutdown_model host_shutdown_model_inst (.mclk(mclk), .srst(srst), .go(go),
    .mode(mode), .hStb(hStb), .hAddr(hAddr), .hData(hData), .done(done));
  initial forever #20 mclk = !mclk;
  ////////////////////////////////////////////////////////////////////////////////
  task automatic ck(input string nm, input logic [15:0] s, input logic [15:0] e);
    n_compared++;
    if (s !== e) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic wr(input logic [8:0] a, input logic [15:0] d);
    @(posedge mclk);
    tStb <= 1'b1;
    tAddr <= a;
    tData <= d;
    @(posedge mclk);
    tStb <= 1'b0;
  endtask
  task automatic rd(input logic [8:0] a, input logic [15:0] e);
    @(posedge mclk);
    rdAddr <= a;
    repeat (3) @(posedge mclk);
    @(negedge mclk);
    ck("read", rdData, e);
  endtask
  task automatic stat(input logic [7:0] e);
    repeat (4) @(posedge mclk);
    @(negedge mclk);
    ck("status", {8'h00, st}, {8'h00, e});
  endtask
  // short reset of two cycles; the host resets the sensor before each clock shutdown
  task automatic rs();
    @(posedge mclk);
    srst <= 1'b1;
    repeat (2) @(posedge mclk);
    srst <= 1'b0;
  endtask
  task automatic results();
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // hang guard well above the expected few hundred cycles
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      failures++;
      results();
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20) @(posedge mclk);
    srst <= 1'b0;
    stat(8'hD0);
    rd(`ADDR_CLOCK_GEN, 16'h200F);
    rd(`ADDR_LOGIC_ENABLE, 16'h0001);
    rd(`ADDR_PLL_ENABLE, 16'h0001);
    rd(`ADDR_CLOCK_MGMT, 16'h0001);
    rd(`ADDR_PLL_SOFT_RESET, 16'h0000);
    // static registers and one unmapped address written with the sequencer off, then read back
    foreach (rows[i]) begin
      wr(rows[i][40:32], rows[i][31:16]);
      rd(rows[i][40:32], rows[i][15:0]);
    end
    // full shutdown in every mode
    for (int m = 0; m < 4; m++) begin
      rs();
      mode <= m[1:0];
      go <= 1'b1;
      @(posedge mclk);
      go <= 1'b0;
      repeat (2) @(posedge mclk);
      for (int i = 0; i < 40 && done !== 1'b1; i++) @(posedge mclk);
      stat(8'h28);
      rd(`ADDR_CLOCK_GEN, offTab[m]);
    end
    rs();
    wr(`ADDR_SEQ_CTRL, `VAL_SEQ_START);
    stat(8'hD4);
    wr(9'h0CB, 16'h0100);
    wr(9'h0CC, 16'h0010);
    wr(9'h0E8, 16'h0001);
    stat(8'hD4);
    wr(`ADDR_FRONT_END, 16'h0001);
    fc = 1'b0;
    repeat (4) begin
      @(negedge mclk);
      fc = fc | st[1];
    end
    ck("corrupt", {15'h0000, fc}, 16'h0001);
    wr(`ADDR_CLOCK_GEN, 16'h200F);
    stat(8'hD5);
    wr(`ADDR_SEQ_CTRL, `VAL_SEQ_STOP);
    stat(8'hD0);
    @(posedge mclk);
    pllBypass <= 1'b1;
    lvdsClkPin <= 1'b1;
    repeat (8) @(posedge mclk);
    @(negedge mclk);
    ck("refsel", {15'h0000, clk_shutdown_regs_inst.refClk}, 16'h0001);
    @(posedge mclk);
    pllBypass <= 1'b0;
    repeat (8) @(posedge mclk);
    @(negedge mclk);
    ck("refsel", {15'h0000, clk_shutdown_regs_inst.refClk}, 16'h0000);
    results();
  end
endmodule // sensor_clock_shutdown_and_reconfig_tb_top
`default_nettype wire
